// ---- logic/evc_pkg.sv ----
// Purpose: constants for the extreme value capture and primary control block
// Assumes: byte-wide register port, offsets as printed
// Notes: shared by the top and the checker
package evc_pkg;
    // ***************************************************************
    // register offsets
    // ***************************************************************
    localparam logic [7:0] TEMP_LOW_MARK_HIGH_ADDR = 8'h1F;
    localparam logic [7:0] TEMP_LOW_MARK_LOW_ADDR = 8'h20;
    localparam logic [7:0] PEAK_BARO_HIGH_ADDR = 8'h21;
    localparam logic [7:0] PEAK_BARO_CENTRE_ADDR = 8'h22;
    localparam logic [7:0] PEAK_BARO_LOW_ADDR = 8'h23;
    localparam logic [7:0] TEMP_HIGH_MARK_HIGH_ADDR = 8'h24;
    localparam logic [7:0] TEMP_HIGH_MARK_LOW_ADDR = 8'h25;
    localparam logic [7:0] PRIMARY_CONTROL_ADDR = 8'h26;

    // ***************************************************************
    // primary control fields and reset values
    // ***************************************************************
    localparam int CTL_ALT_BIT = 7;
    localparam int CTL_RAW_BIT = 6;
    localparam int CTL_OS_HI = 5;
    localparam int CTL_OS_LO = 3;
    localparam int CTL_RST_BIT = 2;
    localparam int CTL_OST_BIT = 1;
    localparam int CTL_SBY_BIT = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] FRAC_MASK = 8'hF0;
    localparam logic [19:0] BARO_RESET = 20'h00000;
    localparam logic [11:0] TEMP_RESET = 12'h000;

    // ***************************************************************
    // widths and timing
    // ***************************************************************
    localparam int BARO_W = 20;
    localparam int TEMP_W = 12;
    localparam int OS_W = 3;
    localparam int BOOT_CYCLES = 4;
    localparam logic [2:0] BOOT_LAST = 3'h3;

    typedef enum logic [2:0]
    {
        EVC_IDLE = 3'b001,
        EVC_BOOT = 3'b010,
        EVC_SHOT = 3'b100
    } evc_state_t;
endpackage

// ---- logic/evc_tracker.sv ----
// Purpose: keeps one running extreme of a sampled value
// Assumes: sample strobe and clear are single-cycle pulses
// Notes: signed or unsigned compare by the signed_i input
`timescale 1ns/1ps
module evc_tracker #(
    parameter int W = 20,
    parameter bit KEEP_MAX = 1'b1
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // control
    input wire logic signed_i,
    input wire logic clear_i,
    input wire logic [W-1:0] load_i,
    input wire logic load_en_i,
    // sample
    input wire logic sample_vld_i,
    input wire logic [W-1:0] sample_i,
    // stored extreme
    output logic [W-1:0] value_o
);
    logic [W-1:0] value_r;
    wire s_gt = $signed(sample_i) > $signed(value_r);
    wire u_gt = sample_i > value_r;
    wire greater = signed_i ? s_gt : u_gt;
    wire lesser = !greater && (sample_i != value_r);
    wire take = sample_vld_i && (KEEP_MAX ? greater : lesser);

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || clear_i)
            value_r <= '0;
        else if (take)
            value_r <= sample_i;
        else if (load_en_i)
            value_r <= load_i;
    end

    assign value_o = value_r;
endmodule

// ---- logic/evc_top.sv ----
// Purpose: extreme value registers and primary control register
// Assumes: byte register port from the serial slave, one 20 MHz clock
// Notes: measurement engine is outside; it strobes results in and takes requests out
`timescale 1ns/1ps
//
// Contract
// (RL1) keep largest pressure or altitude reading
// (RL2) altimeter: signed metres, four-bit fraction
// (RL3) barometer: unsigned pascals, two-bit fraction
// (RL4) extremes zero at reset or zero write
// (RL5) keep lowest temperature reading
// (RL6) temperature signed, fraction bits 7 to 4
// (RL7) keep highest temperature reading
// (RL8) host changes control only in standby
// (RL9) mode bit: 0 barometer, 1 altimeter
// (RL10) raw mode: oversampling only, no correction
// (RL11) host keeps fifo off in raw
// (RL12) raw mode suppresses all interrupt functions
// (RL13) oversample ratio is two to field
// (RL14) active bit: 0 standby, 1 active
// (RL15) one-shot in standby self-clears after measurement
// (RL16) reset bit reloads defaults, reads zero
// (RL17) raw overrides altimeter selection
// (RL18) update extreme only when exceeded
module evc_top
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // measurement engine results
    input wire logic meas_done_i,
    input wire logic [19:0] meas_baro_i,
    input wire logic [11:0] meas_temp_i,
    // measurement engine control
    output logic meas_start_o,
    output logic active_o,
    output logic altimeter_select_o,
    output logic raw_mode_o,
    output logic [2:0] oversample_exponent_o,
    output logic [7:0] oversample_ratio_o,
    output logic irq_enable_o,
    output logic serial_reset_o
);
    // ***************************************************************
    // control state
    // ***************************************************************
    logic alt_r;
    logic raw_r;
    logic [evc_pkg::OS_W-1:0] os_r;
    logic single_shot_trigger_r;
    logic active_select_r;
    logic [2:0] boot_cnt_r;
    evc_pkg::evc_state_t state_r;
    evc_pkg::evc_state_t state_nxt;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic start_r;
    logic srst_r;
    logic shot_busy_r;

    // ***************************************************************
    // decode
    // ***************************************************************
    wire wr_ctl = reg_wr_i && (reg_addr_i == evc_pkg::PRIMARY_CONTROL_ADDR);
    wire wr_pbh = reg_wr_i && (reg_addr_i == evc_pkg::PEAK_BARO_HIGH_ADDR);
    wire wr_pbc = reg_wr_i && (reg_addr_i == evc_pkg::PEAK_BARO_CENTRE_ADDR);
    wire wr_pbl = reg_wr_i && (reg_addr_i == evc_pkg::PEAK_BARO_LOW_ADDR);
    wire wr_tlh = reg_wr_i && (reg_addr_i == evc_pkg::TEMP_LOW_MARK_HIGH_ADDR);
    wire wr_tll = reg_wr_i && (reg_addr_i == evc_pkg::TEMP_LOW_MARK_LOW_ADDR);
    wire wr_thh = reg_wr_i && (reg_addr_i == evc_pkg::TEMP_HIGH_MARK_HIGH_ADDR);
    wire wr_thl = reg_wr_i && (reg_addr_i == evc_pkg::TEMP_HIGH_MARK_LOW_ADDR);
    wire wzero = (reg_wdata_i == evc_pkg::REG_RESET);
    wire soft_rst_req = wr_ctl && reg_wdata_i[evc_pkg::CTL_RST_BIT];
    wire booting = (state_r == evc_pkg::EVC_BOOT);
    wire boot_end = booting && (boot_cnt_r == evc_pkg::BOOT_LAST);
    // boot reloads every register with defaults
    wire blk_rst = rst_i || boot_end; // RL16
    // compensated results only feed the extremes
    wire comp_done = meas_done_i && !raw_r; // RL18 RL10

    // ***************************************************************
    // extreme trackers
    // ***************************************************************
    logic [19:0] peak_baro;
    logic [11:0] temp_low;
    logic [11:0] temp_high;
    logic [19:0] pb_load;
    logic [11:0] tl_load;
    logic [11:0] th_load;
    wire pb_clr = (wr_pbh || wr_pbc || wr_pbl) && wzero; // RL4
    wire tl_clr = (wr_tlh || wr_tll) && wzero; // RL4
    wire th_clr = (wr_thh || wr_thl) && wzero; // RL4
    // nonzero byte writes replace that byte; reserved low bits dropped
    assign pb_load = wr_pbh ? {reg_wdata_i, peak_baro[11:0]} :
                     wr_pbc ? {peak_baro[19:12], reg_wdata_i, peak_baro[3:0]} :
                     {peak_baro[19:4], reg_wdata_i[7:4]};
    assign tl_load = wr_tlh ? {reg_wdata_i, temp_low[3:0]} :
                     {temp_low[11:4], reg_wdata_i[7:4]};
    assign th_load = wr_thh ? {reg_wdata_i, temp_high[3:0]} :
                     {temp_high[11:4], reg_wdata_i[7:4]};

    // altimeter values compare signed, barometer unsigned
    evc_tracker #(.W(evc_pkg::BARO_W), .KEEP_MAX(1'b1)) u_peak_baro // RL1 RL2 RL3
    (
        .sys_clk_i(sys_clk_i),
        .rst_i(blk_rst),
        .signed_i(alt_r),
        .clear_i(pb_clr),
        .load_i(pb_load),
        .load_en_i((wr_pbh || wr_pbc || wr_pbl) && !wzero),
        .sample_vld_i(comp_done),
        .sample_i(meas_baro_i),
        .value_o(peak_baro)
    );

    evc_tracker #(.W(evc_pkg::TEMP_W), .KEEP_MAX(1'b0)) u_temp_low // RL5 RL6
    (
        .sys_clk_i(sys_clk_i),
        .rst_i(blk_rst),
        .signed_i(1'b1),
        .clear_i(tl_clr),
        .load_i(tl_load),
        .load_en_i((wr_tlh || wr_tll) && !wzero),
        .sample_vld_i(comp_done),
        .sample_i(meas_temp_i),
        .value_o(temp_low)
    );

    evc_tracker #(.W(evc_pkg::TEMP_W), .KEEP_MAX(1'b1)) u_temp_high // RL7 RL6
    (
        .sys_clk_i(sys_clk_i),
        .rst_i(blk_rst),
        .signed_i(1'b1),
        .clear_i(th_clr),
        .load_i(th_load),
        .load_en_i((wr_thh || wr_thl) && !wzero),
        .sample_vld_i(comp_done),
        .sample_i(meas_temp_i),
        .value_o(temp_high)
    );

    // ***************************************************************
    // read mux
    // ***************************************************************
    wire [7:0] ctl_rd = {alt_r, raw_r, os_r, 1'b0, single_shot_trigger_r, active_select_r};
    logic [7:0] rd_mux;
    always_comb
    begin
        case (reg_addr_i)
            evc_pkg::TEMP_LOW_MARK_HIGH_ADDR: rd_mux = temp_low[11:4];
            evc_pkg::TEMP_LOW_MARK_LOW_ADDR: rd_mux = {temp_low[3:0], 4'h0}; // RL6
            evc_pkg::PEAK_BARO_HIGH_ADDR: rd_mux = peak_baro[19:12];
            evc_pkg::PEAK_BARO_CENTRE_ADDR: rd_mux = peak_baro[11:4];
            evc_pkg::PEAK_BARO_LOW_ADDR: rd_mux = {peak_baro[3:0], 4'h0};
            evc_pkg::TEMP_HIGH_MARK_HIGH_ADDR: rd_mux = temp_high[11:4];
            evc_pkg::TEMP_HIGH_MARK_LOW_ADDR: rd_mux = {temp_high[3:0], 4'h0};
            evc_pkg::PRIMARY_CONTROL_ADDR: rd_mux = ctl_rd; // RL16
            default: rd_mux = evc_pkg::REG_RESET;
        endcase
    end

    // ***************************************************************
    // sequencer
    // ***************************************************************
    // boot runs a fixed count, then reloads all defaults
    always_comb
    begin
        case (state_r)
            evc_pkg::EVC_IDLE:
                state_nxt = soft_rst_req ? evc_pkg::EVC_BOOT : state_r;
            evc_pkg::EVC_BOOT:
                state_nxt = boot_end ? evc_pkg::EVC_IDLE : state_r;
            default:
                state_nxt = evc_pkg::EVC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_r <= evc_pkg::EVC_IDLE;
            boot_cnt_r <= 3'h0;
        end
        else
        begin
            state_r <= state_nxt;
            boot_cnt_r <= booting ? boot_cnt_r + 3'h1 : 3'h0;
        end
    end

    // ***************************************************************
    // primary control register
    // ***************************************************************
    // a trigger already pending does not restart the engine
    wire shot_req = wr_ctl && reg_wdata_i[evc_pkg::CTL_OST_BIT] && !single_shot_trigger_r;
    always_ff @(posedge sys_clk_i)
    begin
        if (blk_rst)
        begin
            alt_r <= 1'b0; // RL9
            raw_r <= 1'b0;
            os_r <= '0; // RL13
            active_select_r <= 1'b0; // RL14
            single_shot_trigger_r <= 1'b0;
        end
        else if (booting || soft_rst_req)
        begin
            active_select_r <= 1'b0; // RL16
        end
        else if (wr_ctl)
        begin
            // field changes are expected only from standby
            alt_r <= reg_wdata_i[evc_pkg::CTL_ALT_BIT]; // RL8 RL9
            raw_r <= reg_wdata_i[evc_pkg::CTL_RAW_BIT]; // RL10 RL11
            os_r <= reg_wdata_i[evc_pkg::CTL_OS_HI:evc_pkg::CTL_OS_LO]; // RL13
            active_select_r <= reg_wdata_i[evc_pkg::CTL_SBY_BIT]; // RL14
            single_shot_trigger_r <= reg_wdata_i[evc_pkg::CTL_OST_BIT];
        end
        else if (meas_done_i && shot_busy_r && !active_select_r)
        begin
            single_shot_trigger_r <= 1'b0; // RL15
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (blk_rst || booting)
            shot_busy_r <= 1'b0;
        else if (shot_req)
            shot_busy_r <= 1'b1; // RL15
        else if (meas_done_i)
            shot_busy_r <= 1'b0;
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rdata_r <= evc_pkg::REG_RESET;
            rvalid_r <= 1'b0;
            start_r <= 1'b0;
            srst_r <= 1'b0;
        end
        else
        begin
            rdata_r <= reg_rd_i ? rd_mux : rdata_r;
            rvalid_r <= reg_rd_i;
            start_r <= shot_req && !booting; // RL15
            srst_r <= booting; // RL16
        end
    end

    // engine control outputs lag the register by one cycle
    logic act_q;
    logic alt_q;
    logic raw_q;
    logic irq_q;
    logic [2:0] os_q;
    logic [7:0] ratio_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            act_q <= 1'b0;
            alt_q <= 1'b0;
            raw_q <= 1'b0;
            irq_q <= 1'b0;
            os_q <= 3'h0;
            ratio_q <= 8'h01;
        end
        else
        begin
            act_q <= active_select_r || shot_busy_r; // RL14 RL15
            alt_q <= alt_r && !raw_r; // RL17
            raw_q <= raw_r; // RL10
            irq_q <= !raw_r; // RL12
            os_q <= os_r;
            ratio_q <= 8'h01 << os_r; // RL13
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;
    assign meas_start_o = start_r;
    assign active_o = act_q;
    assign altimeter_select_o = alt_q;
    assign raw_mode_o = raw_q;
    assign oversample_exponent_o = os_q;
    assign oversample_ratio_o = ratio_q;
    assign irq_enable_o = irq_q;
    assign serial_reset_o = srst_r;
endmodule

// ---- sim/evc_chk_sva.sv ----
// Purpose: port checks for the extreme value block
// Assumes: one clock, synchronous reset
// Notes: bound to evc_top
`timescale 1ns/1ps
module evc_chk
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // engine control
    input wire logic meas_start_o,
    input wire logic active_o,
    input wire logic altimeter_select_o,
    input wire logic raw_mode_o,
    input wire logic [2:0] oversample_exponent_o,
    input wire logic [7:0] oversample_ratio_o,
    input wire logic irq_enable_o,
    input wire logic serial_reset_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire ctl_wr = reg_wr_i && reg_addr_i == evc_pkg::PRIMARY_CONTROL_ADDR;
    wire lsb_rd = reg_rd_i && (reg_addr_i == 8'h20 || reg_addr_i == 8'h23 || reg_addr_i == 8'h25);
    property p_rd;
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_nord;
        !reg_rd_i |=> !reg_rvalid_o;
    endproperty
    a_nord: assert property (p_nord) else $error("read valid without read");
    property p_lsb;
        lsb_rd |=> reg_rdata_o[3:0] == 4'h0;
    endproperty
    a_lsb: assert property (p_lsb) else $error("low nibble not zero");
    property p_rst0;
        reg_rd_i && reg_addr_i == 8'h26 |=> !reg_rdata_o[2];
    endproperty
    a_rst0: assert property (p_rst0) else $error("reset bit read as one");
    property p_ratio;
        oversample_ratio_o == (8'h01 << oversample_exponent_o);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio wrong");
    property p_raw;
        raw_mode_o |-> !altimeter_select_o && !irq_enable_o;
    endproperty
    a_raw: assert property (p_raw) else $error("raw mode leak");
    property p_shot;
        ctl_wr && reg_wdata_i[2:0] == 3'h2 && !active_o && !serial_reset_o
        |=> meas_start_o ##1 active_o;
    endproperty
    a_shot: assert property (p_shot) else $error("one shot not started");
    property p_act;
        ctl_wr && reg_wdata_i[2:0] == 3'h1 && !serial_reset_o |=> ##1 active_o;
    endproperty
    a_act: assert property (p_act) else $error("active not set");
    property p_boot;
        ctl_wr && reg_wdata_i[2] && !serial_reset_o |-> ##[1:2] serial_reset_o;
    endproperty
    a_boot: assert property (p_boot) else $error("boot not entered");
endmodule
bind evc_top evc_chk u_chk (.*);

// ---- sim/evc_host.sv ----
// Purpose: host side of the register port
// Assumes: one-cycle strobes, driven on falling edge
// Notes: released lines show inverted data
`timescale 1ns/1ps
module evc_host
(
    input wire logic sys_clk_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    initial
    begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        d = 8'hXX;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge sys_clk_i);
            reg_rd_o = 1'b0;
            reg_addr_o = ~a;
            if (reg_rvalid_i === 1'b1)
            begin
                d = reg_rdata_i;
                break;
            end
        end
    endtask
endmodule

// ---- sim/tb.sv ----
// Purpose: self-checking bench for evc_top
// Assumes: 20 MHz clock, host model drives the register port
// Notes: engine results driven here
`timescale 1ns/1ps
module tb;
    logic sys_clk_i;
    logic rst_i;
    logic wr, rd, rvalid, done, start, act, altimeter_select, raw, irq, srst;
    logic [7:0] addr, wdata, rdata, osr, v;
    logic [2:0] ose;
    logic [19:0] baro;
    logic [11:0] temp;
    int bad_count;
    int total_checks;
    int cyc = 0;
    // address, write data, expected read
    logic [23:0] rows [0:9] = '{24'h1FA5A5, 24'h20BCB0, 24'h211212, 24'h223434, 24'h235F50,
        24'h247E7E, 24'h25FFF0, 24'h263838, 24'h305500, 24'h1E5500};
    evc_host host (.sys_clk_i(sys_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
    evc_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .meas_done_i(done), .meas_baro_i(baro), .meas_temp_i(temp), .meas_start_o(start),
        .active_o(act), .altimeter_select_o(altimeter_select), .raw_mode_o(raw),
        .oversample_exponent_o(ose), .oversample_ratio_o(osr), .irq_enable_o(irq),
        .serial_reset_o(srst));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic zeros;
        for (int a = 8'h1F; a <= 8'h26; a++)
            rdc(8'(a), 8'h00);
    endtask
    // one-shot measurement with given results
    task automatic shot(input logic [7:0] c, input logic [19:0] b, input logic [11:0] t);
        host.wr(8'h26, c | 8'h02);
        for (int i = 0; i < 8 && start !== 1'b1; i++)
            @(negedge sys_clk_i);
        chk("start", 8'h01, {7'h0, start});
        @(negedge sys_clk_i);
        baro = b;
        temp = t;
        done = 1'b1;
        @(negedge sys_clk_i);
        done = 1'b0;
        baro = ~b;
        temp = ~t;
        repeat (3) @(negedge sys_clk_i);
    endtask
    initial
    begin
        rst_i = 1'b1;
        done = 1'b0;
        baro = 20'h00000;
        temp = 12'h000;
        bad_count = 0;
        total_checks = 0;
        repeat (16) @(negedge sys_clk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            host.wr(rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][7:0]);
        end
        chk("ratio", 8'h80, osr);
        chk("os exp", 8'h07, {5'h0, ose});
        host.wr(8'h22, 8'h00);
        rdc(8'h21, 8'h00);
        host.wr(8'h26, 8'h04);
        @(negedge sys_clk_i);
        chk("boot", 8'h01, {7'h0, srst});
        repeat (7) @(negedge sys_clk_i);
        chk("boot end", 8'h00, {7'h0, srst});
        zeros();
        shot(8'h00, 20'h12345, 12'h1A3);
        rdc(8'h23, 8'h50);
        rdc(8'h24, 8'h1A);
        rdc(8'h25, 8'h30);
        rdc(8'h26, 8'h00);
        shot(8'h00, 20'h10000, 12'hF80);
        rdc(8'h22, 8'h34);
        rdc(8'h1F, 8'hF8);
        rdc(8'h24, 8'h1A);
        shot(8'h00, 20'hF0000, 12'h000);
        rdc(8'h21, 8'hF0);
        host.wr(8'h21, 8'h00);
        shot(8'h80, 20'hFFF00, 12'h100);
        rdc(8'h21, 8'h00);
        chk("alt", 8'h01, {7'h0, altimeter_select});
        chk("irq", 8'h01, {7'h0, irq});
        shot(8'h80, 20'h00120, 12'h100);
        rdc(8'h22, 8'h12);
        // raw with no fifo in this block
        host.wr(8'h26, 8'hC0);
        repeat (2) @(negedge sys_clk_i);
        chk("raw", 8'h01, {7'h0, raw});
        chk("alt raw", 8'h00, {7'h0, altimeter_select});
        chk("irq raw", 8'h00, {7'h0, irq});
        shot(8'hC0, 20'h7FFFF, 12'h7FF);
        rdc(8'h22, 8'h12);
        host.wr(8'h26, 8'h00);
        host.wr(8'h26, 8'h01);
        repeat (2) @(negedge sys_clk_i);
        chk("active", 8'h01, {7'h0, act});
        // trigger while active stays set after the result
        shot(8'h01, 20'h00000, 12'h000);
        rdc(8'h26, 8'h03);
        host.wr(8'h26, 8'h00);
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b0;
        zeros();
        tally_and_finish();
    end
endmodule
